/* core/srcc_defs.vh */
// Constants for the supply remote command core: opcodes, bit positions,
// defaults and timing. Assumes a host-side parser that turns text commands
// into one opcode, a channel number and a numeric argument.
//
// Operation
// - Operation-complete command sets event bit 0 once nothing is pending.
// - Operation-complete query answers ASCII 1 when idle, event register untouched.
// - Recall takes location 0 to 99 and restores the stored setting data.
// - Save takes location 0 to 99 and stores the present setting data.
// - Reset command restores all documented defaults but keeps stored setups.
// - Service request mask bit 6 always reads zero; bits mirror the status byte.
// - Status byte query returns 0 to 255 showing the bits now set.
// - Self-test answers 0 on success and -300 on failure.
// - Wait command holds off later commands until nothing is pending.
// - Current setpoint takes channel 1 to 3 and sets or returns the limit.
// - Voltage setpoint takes channel 1 to 3 and sets or returns the limit.
// - Measurement queries return delivered current or voltage, not setpoints.
// - Overcurrent guard is boolean, 0 off and 1 on, and reads back.
// - Overvoltage guard limit per channel is stored and returned.
// - Tracking mode codes: 0 independent, 1 parallel, 2 series; reads back.
// - While a protection message shows, setting commands are rejected until cleared.
// - Output state takes 0 off and 1 on and reads back.
// - Operation condition query always returns zero.
// - An enabled operation event bit drives its summary bit to 1.
// - Operation enable mask keeps bits 0 to 14; bit 15 reads zero.
// - Identification returns maker, model, serial and firmware fields.
// - Event bits latch rising conditions and hold until read or cleared.
// - Masked standard event register is summarised on status bit 5.
`ifndef SRCC_DEFS_VH
`define SRCC_DEFS_VH
`define SRCC_OP_CLS 6'h00
`define SRCC_OP_ESE_W 6'h01
`define SRCC_OP_ESE_R 6'h02
`define SRCC_OP_ESR_R 6'h03
`define SRCC_OP_IDN 6'h04
`define SRCC_OP_OPC 6'h05
`define SRCC_OP_OPC_Q 6'h06
`define SRCC_OP_RCL 6'h07
`define SRCC_OP_RST 6'h08
`define SRCC_OP_SAV 6'h09
`define SRCC_OP_SRE_W 6'h0a
`define SRCC_OP_SRE_R 6'h0b
`define SRCC_OP_STB_R 6'h0c
`define SRCC_OP_TST 6'h0d
`define SRCC_OP_WAI 6'h0e
`define SRCC_OP_CURR_W 6'h0f
`define SRCC_OP_CURR_R 6'h10
`define SRCC_OP_VOLT_W 6'h11
`define SRCC_OP_VOLT_R 6'h12
`define SRCC_OP_MEAS_I 6'h13
`define SRCC_OP_MEAS_V 6'h14
`define SRCC_OP_OCP_W 6'h15
`define SRCC_OP_OCP_R 6'h16
`define SRCC_OP_OVP_W 6'h17
`define SRCC_OP_OVP_R 6'h18
`define SRCC_OP_TRK_W 6'h19
`define SRCC_OP_TRK_R 6'h1a
`define SRCC_OP_PCLR 6'h1b
`define SRCC_OP_OUT_W 6'h1c
`define SRCC_OP_OUT_R 6'h1d
`define SRCC_OP_OCOND_R 6'h1e
`define SRCC_OP_OEN_W 6'h1f
`define SRCC_OP_OEN_R 6'h20
`define SRCC_OP_OEVT_R 6'h21
`define SRCC_OP_PRESET 6'h22
`define SRCC_OPC_BIT 0
`define SRCC_EXE_ERR_BIT 4
`define SRCC_ESB_BIT 5
`define SRCC_MSS_BIT 6
`define SRCC_OSUM_BIT 7
`define SRCC_SRE_KEEP 8'hbf
`define SRCC_OEN_KEEP 15'h7fff
`define SRCC_ASCII_ONE 16'h0031
`define SRCC_TST_FAIL 16'hfed4
`define SRCC_LOC_MAX 7'h63
`define SRCC_TRK_MAX 2'h2
`define SRCC_DLY_UNIT_MS 100
`define SRCC_DLY_RST_MS 1000
`define SRCC_DLY_RST 16'h000a
`define SRCC_AUTO_START_RST 7'h00
`define SRCC_AUTO_END_RST 7'h05
`define SRCC_AUTO_CYCLE_RST 17'h00001
`define SRCC_STEP_MIN 2'h0
`define SRCC_TRK_INDEPENDENT_OUTPUTS 2'h0
`endif

/* core/srcc_core.v */
// Command interpreter core of a programmable multi-channel supply.
// Assumes a parser ahead of it that issues one decoded command per accepted
// cycle and a response consumer that takes every RSP_VALID word at once.
`timescale 1ns/1ps
`include "srcc_defs.vh"
module srcc_core #(
	parameter W = 16,
	parameter NCH = 3,
	parameter DEPTH = 100,
	parameter [15:0] OVP_MAX = 16'hffff,
	parameter [15:0] MFR_ID = 16'h00a5,
	parameter [15:0] MODEL_ID = 16'h0001,
	parameter [15:0] SERIAL_NO = 16'h0000,
	parameter [15:0] FW_REV = 16'h0100
) (
	input wire REF_CLK,
	input wire SYS_RST,
	input wire CMD_VALID,
	input wire [5:0] CMD_OP,
	input wire [1:0] CMD_CHAN,
	input wire [W-1:0] CMD_ARG,
	input wire OP_PENDING,
	input wire TEST_FAULT,
	input wire [2:0] PROT_TRIP,
	input wire [3*W-1:0] MEAS_I,
	input wire [3*W-1:0] MEAS_V,
	output reg CMD_READY,
	output reg RSP_VALID,
	output reg RSP_LAST,
	output reg [W-1:0] RSP_DATA,
	output reg ERR_PULSE,
	output reg SRQ,
	output reg OUTPUT_ON,
	output reg [1:0] TRACK_MODE,
	output reg [3*W-1:0] SET_I,
	output reg [3*W-1:0] SET_V,
	output reg [3*W-1:0] OVP_LVL,
	output reg [2:0] OCP_ON,
	output reg [2:0] PROT_MSG,
	output reg AUTO_ON,
	output reg [15:0] AUTO_DELAY,
	output reg [6:0] AUTO_START,
	output reg [6:0] AUTO_END,
	output reg [16:0] AUTO_CYCLE,
	output reg [1:0] STEP_SEL,
	output reg [6:0] MEM_LOC
);
	localparam SW = 9 * W + 6;
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_IDN = 2'h2;
	// Nothing on this supply feeds the operation condition register.
	localparam [14:0] OPER_COND = 15'h0000;

	// Registered sequencer and status state.
	reg [1:0] st_q;
	reg [5:0] wop_q;
	reg [1:0] idx_q;
	reg [7:0] standard_event_register_q;
	reg [7:0] ese_q;
	reg [7:0] sre_q;
	reg [14:0] oen_q;
	reg [14:0] oevt_q;
	reg [14:0] ocond_q;
	// Setup memory: one snapshot of tracking, output, guard and setpoint settings per location.
	reg [SW-1:0] mem_q [0:DEPTH-1];

	// Decode results of the current cycle.
	reg acc;
	reg bad;
	reg rsp_v;
	reg [W-1:0] rsp_d;
	reg [7:0] standard_event_register_set;
	reg [7:0] standard_event_register_clr;
	reg [14:0] oevt_clr;
	reg opc_done;
	reg done_wait;
	// Channels are numbered from one, the setpoint slices from zero.
	wire [1:0] ch = CMD_CHAN - 2'h1;
	wire [SW-1:0] snap = {TRACK_MODE, OUTPUT_ON, OCP_ON, OVP_LVL, SET_V, SET_I};
	// Status byte: operation summary on bit 7, request summary on 6, event summary on 5.
	wire event_summary_bit = |(standard_event_register_q & ese_q);
	wire osum = |(oevt_q & oen_q);
	wire [7:0] stb_low = {osum, 1'b0, event_summary_bit, 5'h00};
	wire mss = |(stb_low & sre_q);
	wire [7:0] stb = stb_low | {1'b0, mss, 6'h00};

	// True for commands that carry a channel number.
	function chan_op;
		input [5:0] op;
		begin
			chan_op = (op >= `SRCC_OP_CURR_W) && (op <= `SRCC_OP_OVP_R);
		end
	endfunction

	// True for the setting writes and recall, which protection blocks; the reset command is not among them.
	function set_op;
		input [5:0] op;
		begin
			set_op = (op == `SRCC_OP_CURR_W) || (op == `SRCC_OP_VOLT_W) ||
				(op == `SRCC_OP_OCP_W) || (op == `SRCC_OP_OVP_W) ||
				(op == `SRCC_OP_TRK_W) || (op == `SRCC_OP_OUT_W) ||
				(op == `SRCC_OP_RCL);
		end
	endfunction

	// Command acceptance, range checks and the answer word for queries.
	always @* begin
		acc = CMD_VALID && CMD_READY && (st_q == ST_IDLE);
		bad = 1'b0;
		if (chan_op(CMD_OP) && ((CMD_CHAN == 2'h0) || (CMD_CHAN > NCH))) begin
			bad = 1'b1;
		end
		if (((CMD_OP == `SRCC_OP_RCL) || (CMD_OP == `SRCC_OP_SAV)) &&
			(CMD_ARG > `SRCC_LOC_MAX)) begin
			bad = 1'b1;
		end
		if (((CMD_OP == `SRCC_OP_OCP_W) || (CMD_OP == `SRCC_OP_OUT_W)) && (CMD_ARG > 1)) begin
			bad = 1'b1;
		end
		if ((CMD_OP == `SRCC_OP_TRK_W) && ((CMD_ARG > `SRCC_TRK_MAX) || (NCH < 2))) begin
			bad = 1'b1;
		end
		if (set_op(CMD_OP) && (PROT_MSG != 3'h0)) begin
			bad = 1'b1;
		end
		done_wait = (st_q == ST_WAIT) && !OP_PENDING;
		opc_done = (acc && !bad && (CMD_OP == `SRCC_OP_OPC) && !OP_PENDING) ||
			(done_wait && (wop_q == `SRCC_OP_OPC));
		standard_event_register_set = 8'h00;
		standard_event_register_set[`SRCC_OPC_BIT] = opc_done;
		standard_event_register_set[`SRCC_EXE_ERR_BIT] = acc && bad;
		standard_event_register_clr = 8'h00;
		oevt_clr = 15'h0000;
		if (acc && ((CMD_OP == `SRCC_OP_ESR_R) || (CMD_OP == `SRCC_OP_CLS))) begin
			standard_event_register_clr = 8'hff;
		end
		if (acc && ((CMD_OP == `SRCC_OP_OEVT_R) || (CMD_OP == `SRCC_OP_CLS))) begin
			oevt_clr = 15'h7fff;
		end
		rsp_v = 1'b0;
		rsp_d = {W{1'b0}};
		if (st_q == ST_IDN) begin
			rsp_v = 1'b1;
			case (idx_q)
				2'h0: rsp_d = MFR_ID[W-1:0];
				2'h1: rsp_d = MODEL_ID[W-1:0];
				2'h2: rsp_d = SERIAL_NO[W-1:0];
				default: rsp_d = FW_REV[W-1:0];
			endcase
		end else if (done_wait && (wop_q == `SRCC_OP_OPC_Q)) begin
			rsp_v = 1'b1;
			rsp_d = `SRCC_ASCII_ONE;
		end else if (acc && !bad) begin
			rsp_v = 1'b1;
			case (CMD_OP)
				`SRCC_OP_ESE_R: rsp_d = {{(W-8){1'b0}}, ese_q};
				`SRCC_OP_ESR_R: rsp_d = {{(W-8){1'b0}}, standard_event_register_q};
				`SRCC_OP_SRE_R: rsp_d = {{(W-8){1'b0}}, sre_q};
				`SRCC_OP_STB_R: rsp_d = {{(W-8){1'b0}}, stb};
				`SRCC_OP_TST: rsp_d = TEST_FAULT ? `SRCC_TST_FAIL : {W{1'b0}};
				`SRCC_OP_OPC_Q: begin
					rsp_v = !OP_PENDING;
					rsp_d = `SRCC_ASCII_ONE;
				end
				`SRCC_OP_CURR_R: rsp_d = SET_I[ch*W +: W];
				`SRCC_OP_VOLT_R: rsp_d = SET_V[ch*W +: W];
				`SRCC_OP_MEAS_I: rsp_d = MEAS_I[ch*W +: W];
				`SRCC_OP_MEAS_V: rsp_d = MEAS_V[ch*W +: W];
				`SRCC_OP_OCP_R: rsp_d = {{(W-1){1'b0}}, OCP_ON[ch]};
				`SRCC_OP_OVP_R: rsp_d = OVP_LVL[ch*W +: W];
				`SRCC_OP_TRK_R: rsp_d = {{(W-2){1'b0}}, TRACK_MODE};
				`SRCC_OP_OUT_R: rsp_d = {{(W-1){1'b0}}, OUTPUT_ON};
				`SRCC_OP_OCOND_R: rsp_d = {W{1'b0}};
				`SRCC_OP_OEN_R: rsp_d = {{(W-15){1'b0}}, oen_q};
				`SRCC_OP_OEVT_R: rsp_d = {{(W-15){1'b0}}, oevt_q};
				default: rsp_v = 1'b0;
			endcase
		end
	end

	// Default settings, shared by power-on reset and the reset command.
	// Stored setups are deliberately left alone here.
	task load_defaults;
		begin
			OUTPUT_ON <= 1'b0;
			SET_I <= {3*W{1'b0}};
			SET_V <= {3*W{1'b0}};
			OCP_ON <= 3'h0;
			AUTO_DELAY <= `SRCC_DLY_RST;
			AUTO_ON <= 1'b0;
			MEM_LOC <= 7'h00;
			OVP_LVL <= {3{OVP_MAX[W-1:0]}};
			TRACK_MODE <= `SRCC_TRK_INDEPENDENT_OUTPUTS;
			STEP_SEL <= `SRCC_STEP_MIN;
			AUTO_START <= `SRCC_AUTO_START_RST;
			AUTO_END <= `SRCC_AUTO_END_RST;
			AUTO_CYCLE <= `SRCC_AUTO_CYCLE_RST;
		end
	endtask

	// Setup memory has no reset, so a location never saved recalls unknown data.
	always @(posedge REF_CLK) begin
		if (acc && !bad && (CMD_OP == `SRCC_OP_SAV)) begin
			mem_q[CMD_ARG[6:0]] <= snap;
		end
	end

	// Sequencer, status registers and settings.
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			load_defaults;
			st_q <= ST_IDLE;
			wop_q <= 6'h00;
			idx_q <= 2'h0;
			standard_event_register_q <= 8'h00;
			ese_q <= 8'h00;
			sre_q <= 8'h00;
			oen_q <= 15'h0000;
			oevt_q <= 15'h0000;
			ocond_q <= 15'h0000;
			CMD_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_LAST <= 1'b0;
			RSP_DATA <= {W{1'b0}};
			ERR_PULSE <= 1'b0;
			SRQ <= 1'b0;
			PROT_MSG <= 3'h0;
		end else begin
			RSP_VALID <= rsp_v;
			RSP_DATA <= rsp_d;
			RSP_LAST <= rsp_v;
			ERR_PULSE <= acc && bad;
			SRQ <= mss;
			// A new event in the clearing cycle survives: set beats clear.
			standard_event_register_q <= (standard_event_register_q & ~standard_event_register_clr) | standard_event_register_set;
			ocond_q <= OPER_COND;
			oevt_q <= (oevt_q & ~oevt_clr) | (OPER_COND & ~ocond_q);
			// Messages are sticky; a trip arriving in the clearing cycle is kept.
			if (acc && (CMD_OP == `SRCC_OP_PCLR)) begin
				PROT_MSG <= PROT_TRIP;
			end else begin
				PROT_MSG <= PROT_MSG | PROT_TRIP;
			end
			case (st_q)
				ST_IDLE: begin
					CMD_READY <= 1'b1;
					if (acc && !bad) begin
						case (CMD_OP)
							`SRCC_OP_ESE_W: ese_q <= CMD_ARG[7:0];
							`SRCC_OP_SRE_W: sre_q <= CMD_ARG[7:0] & `SRCC_SRE_KEEP;
							`SRCC_OP_OEN_W: oen_q <= CMD_ARG[14:0] & `SRCC_OEN_KEEP;
							`SRCC_OP_PRESET: oen_q <= 15'h0000;
							`SRCC_OP_RST: load_defaults;
							`SRCC_OP_RCL: begin
								{TRACK_MODE, OUTPUT_ON, OCP_ON, OVP_LVL, SET_V, SET_I} <=
									mem_q[CMD_ARG[6:0]];
								MEM_LOC <= CMD_ARG[6:0];
							end
							`SRCC_OP_SAV: MEM_LOC <= CMD_ARG[6:0];
							`SRCC_OP_CURR_W: SET_I[ch*W +: W] <= CMD_ARG;
							`SRCC_OP_VOLT_W: SET_V[ch*W +: W] <= CMD_ARG;
							`SRCC_OP_OCP_W: OCP_ON[ch] <= CMD_ARG[0];
							`SRCC_OP_OVP_W: OVP_LVL[ch*W +: W] <= CMD_ARG;
							`SRCC_OP_TRK_W: TRACK_MODE <= CMD_ARG[1:0];
							`SRCC_OP_OUT_W: OUTPUT_ON <= CMD_ARG[0];
							`SRCC_OP_IDN: begin
								st_q <= ST_IDN;
								idx_q <= 2'h0;
								CMD_READY <= 1'b0;
							end
							`SRCC_OP_OPC, `SRCC_OP_OPC_Q, `SRCC_OP_WAI: begin
								if (OP_PENDING) begin
									st_q <= ST_WAIT;
									wop_q <= CMD_OP;
									CMD_READY <= 1'b0;
								end
							end
							default: st_q <= ST_IDLE;
						endcase
					end
				end
				ST_WAIT: begin
					// Stalling here keeps later commands queued upstream.
					if (done_wait) begin
						st_q <= ST_IDLE;
						CMD_READY <= 1'b1;
					end
				end
				ST_IDN: begin
					idx_q <= idx_q + 2'h1;
					if (idx_q == 2'h3) begin
						st_q <= ST_IDLE;
						CMD_READY <= 1'b1;
					end
				end
				default: begin
					st_q <= ST_IDLE;
					CMD_READY <= 1'b1;
				end
			endcase
		end
	end
endmodule

/* dv/srcc_plant.sv */
// Plant model behind the core: delivered output readings.
// Assumes the core's setpoint outputs, channel n at bits (n-1)*16.
`timescale 1ns/1ps
module srcc_plant (
	input wire [47:0] set_i,
	input wire [47:0] set_v,
	output wire [47:0] meas_i,
	output wire [47:0] meas_v
);
	// Readings are the setpoints XORed with a fixed pattern, so a core that echoes setpoints is caught.
	assign meas_i = set_i ^ {3{16'h0011}};
	assign meas_v = set_v ^ {3{16'h0022}};
endmodule

/* dv/srcc_asserts.sv */
// Checker on the command core ports: answer codes, masks and hold-off.
// Assumes one clock domain and the opcode header.
`timescale 1ns/1ps
`include "srcc_defs.vh"
module srcc_asserts (
	input wire REF_CLK,
	input wire SYS_RST,
	input wire CMD_VALID,
	input wire CMD_READY,
	input wire [5:0] CMD_OP,
	input wire OP_PENDING,
	input wire TEST_FAULT,
	input wire [2:0] PROT_MSG,
	input wire [47:0] SET_I,
	input wire RSP_VALID,
	input wire [15:0] RSP_DATA,
	input wire ERR_PULSE,
	input wire OUTPUT_ON
);
	// A command counts as taken when offered while the core is idle.
	wire tk = CMD_VALID && CMD_READY;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// The identity answer is four words back to back, then silence.
	sequence s_idn;
		RSP_VALID [*4] ##1 !RSP_VALID;
	endsequence
	chk_idn_words: assert property (tk && CMD_OP == `SRCC_OP_IDN |=> !CMD_READY ##1 s_idn)
		else $error("identity words wrong");
	chk_opc_ascii: assert property (tk && CMD_OP == `SRCC_OP_OPC_Q && !OP_PENDING
		|=> RSP_VALID && RSP_DATA == 16'h0031) else $error("completion answer wrong");
	chk_opc_hold: assert property (tk && OP_PENDING && (CMD_OP == `SRCC_OP_WAI || CMD_OP == `SRCC_OP_OPC_Q)
		|=> !CMD_READY && !RSP_VALID) else $error("pending not held off");
	chk_tst_code: assert property (tk && CMD_OP == `SRCC_OP_TST
		|=> RSP_VALID && RSP_DATA == ($past(TEST_FAULT) ? 16'hfed4 : 16'h0000)) else $error("self-test code wrong");
	chk_ocond_zero: assert property (tk && CMD_OP == `SRCC_OP_OCOND_R |=> RSP_VALID && RSP_DATA == 16'h0)
		else $error("condition not zero");
	chk_oen_top: assert property (tk && CMD_OP == `SRCC_OP_OEN_R |=> RSP_VALID && !RSP_DATA[15])
		else $error("enable bit 15 set");
	chk_sre_bit6: assert property (tk && CMD_OP == `SRCC_OP_SRE_R |=> RSP_VALID && !RSP_DATA[6])
		else $error("request mask bit 6 set");
	chk_prot_block: assert property (tk && CMD_OP == `SRCC_OP_CURR_W && PROT_MSG != 3'h0
		|=> ERR_PULSE && $stable(SET_I)) else $error("setting taken under protection");
	chk_rst_dflt: assert property (tk && CMD_OP == `SRCC_OP_RST |=> !OUTPUT_ON && SET_I == 48'h0)
		else $error("reset defaults wrong");
endmodule
bind srcc_core srcc_asserts chk_u (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID),
	.CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .OP_PENDING(OP_PENDING), .TEST_FAULT(TEST_FAULT),
	.PROT_MSG(PROT_MSG), .SET_I(SET_I), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
	.ERR_PULSE(ERR_PULSE), .OUTPUT_ON(OUTPUT_ON));

/* dv/tb.sv */
// Bench for the command core: a table of command rows, then hand tests.
// Assumes the core, the plant model and the checker bind; 10 MHz clock.
`timescale 1ns/1ps
`include "srcc_defs.vh"
module tb;
	typedef struct packed {
		logic [5:0] op;
		logic [1:0] ch;
		logic [15:0] arg;
		logic [1:0] kind;
		logic [15:0] exp;
	} srcc_row_t;
	// Identity words and the guard maximum are arbitrary values.
	localparam [63:0] IDW = 64'h1357_2468_0042_0a0b;
	localparam [15:0] OVMAX = 16'hfff0;
	reg REF_CLK = 1'b0;
	reg SYS_RST = 1'b1;
	reg CMD_VALID = 1'b0;
	reg [5:0] CMD_OP = 6'h0;
	reg [1:0] CMD_CHAN = 2'h0;
	reg [15:0] CMD_ARG = 16'h0;
	reg OP_PENDING = 1'b0;
	reg TEST_FAULT = 1'b0;
	reg [2:0] PROT_TRIP = 3'h0;
	wire CMD_READY, RSP_VALID, RSP_LAST, ERR_PULSE, SRQ, OUTPUT_ON, AUTO_ON;
	wire [1:0] TRACK_MODE, STEP_SEL;
	wire [15:0] RSP_DATA, AUTO_DELAY;
	wire [2:0] OCP_ON, PROT_MSG;
	wire [47:0] MEAS_I, MEAS_V, SET_I, SET_V, OVP_LVL;
	wire [6:0] AUTO_START, AUTO_END, MEM_LOC;
	wire [16:0] AUTO_CYCLE;
	srcc_row_t rows[$];
	integer errors = 0;
	integer n_compared = 0;
	integer i;
	integer k;
	srcc_core #(.OVP_MAX(OVMAX), .MFR_ID(IDW[63:48]), .MODEL_ID(IDW[47:32]), .SERIAL_NO(IDW[31:16]),
		.FW_REV(IDW[15:0])) dut_u (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
		.CMD_CHAN(CMD_CHAN), .CMD_ARG(CMD_ARG), .OP_PENDING(OP_PENDING), .TEST_FAULT(TEST_FAULT),
		.PROT_TRIP(PROT_TRIP), .MEAS_I(MEAS_I), .MEAS_V(MEAS_V), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
		.RSP_LAST(RSP_LAST), .RSP_DATA(RSP_DATA), .ERR_PULSE(ERR_PULSE), .SRQ(SRQ), .OUTPUT_ON(OUTPUT_ON),
		.TRACK_MODE(TRACK_MODE), .SET_I(SET_I), .SET_V(SET_V), .OVP_LVL(OVP_LVL), .OCP_ON(OCP_ON),
		.PROT_MSG(PROT_MSG), .AUTO_ON(AUTO_ON), .AUTO_DELAY(AUTO_DELAY), .AUTO_START(AUTO_START),
		.AUTO_END(AUTO_END), .AUTO_CYCLE(AUTO_CYCLE), .STEP_SEL(STEP_SEL), .MEM_LOC(MEM_LOC));
	srcc_plant pm_u (.set_i(SET_I), .set_v(SET_V), .meas_i(MEAS_I), .meas_v(MEAS_V));
	// Counts a comparison and reports a mismatch at once.
	task cmp(input [15:0] got, input [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task summarize;
		begin
			$display("compared %0d mismatched %0d", n_compared, errors);
			if (errors == 0 && n_compared > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask
	// Offers one command once the core is idle; returns in the cycle after it was taken.
	task cmd(input [5:0] op, input [1:0] ch, input [15:0] arg);
		begin
			for (k = 0; k < 100 && CMD_READY !== 1'b1; k = k + 1) begin
				@(posedge REF_CLK);
				#1;
			end
			if (k == 100) begin
				errors = errors + 1;
				summarize();
			end
			@(posedge REF_CLK);
			CMD_VALID <= 1'b1;
			CMD_OP <= op;
			CMD_CHAN <= ch;
			CMD_ARG <= arg;
			@(posedge REF_CLK);
			CMD_VALID <= 1'b0;
			#1;
		end
	endtask
	// Appends one table row; kind 2 expects an answer, 1 a reject, 0 silence.
	task row(input [5:0] op, input [1:0] ch, input [15:0] arg, input [1:0] kind, input [15:0] exp);
		rows.push_back('{op, ch, arg, kind, exp});
	endtask
	// Settings that both reset paths must leave behind; one second is ten 100 ms steps.
	task dflt;
		begin
			cmp({9'h0, OUTPUT_ON, AUTO_ON, OCP_ON, TRACK_MODE}, 16'h0);
			cmp(SET_I[15:0] | SET_I[31:16] | SET_I[47:32] | SET_V[15:0] | SET_V[31:16] | SET_V[47:32], 16'h0);
			cmp(OVP_LVL[15:0] & OVP_LVL[31:16] & OVP_LVL[47:32], OVMAX);
			cmp(AUTO_DELAY, 16'h03e8 / 16'h0064);
			cmp({2'h0, AUTO_START, AUTO_END}, 16'h0005);
			cmp(AUTO_CYCLE[15:0], 16'h0001);
			cmp({6'h0, AUTO_CYCLE[16], MEM_LOC, STEP_SEL}, 16'h0);
		end
	endtask
	// Free-running clock, 100 ns period.
	initial begin
		forever #50 REF_CLK = ~REF_CLK;
	end
	// Reset, the command table, then the awkward cases.
	initial begin
		row(`SRCC_OP_CURR_W, 2'h2, 16'h1234, 2'h0, 16'h0);
		row(`SRCC_OP_CURR_R, 2'h2, 16'h0, 2'h2, 16'h1234);
		row(`SRCC_OP_VOLT_W, 2'h3, 16'h0abc, 2'h0, 16'h0);
		row(`SRCC_OP_VOLT_R, 2'h3, 16'h0, 2'h2, 16'h0abc);
		row(`SRCC_OP_OCP_W, 2'h1, 16'h1, 2'h0, 16'h0);
		row(`SRCC_OP_OCP_R, 2'h1, 16'h0, 2'h2, 16'h1);
		row(`SRCC_OP_OVP_W, 2'h1, 16'h0777, 2'h0, 16'h0);
		row(`SRCC_OP_OVP_R, 2'h1, 16'h0, 2'h2, 16'h0777);
		row(`SRCC_OP_TRK_W, 2'h0, 16'h2, 2'h0, 16'h0);
		row(`SRCC_OP_TRK_R, 2'h0, 16'h0, 2'h2, 16'h2);
		row(`SRCC_OP_TRK_W, 2'h0, 16'h1, 2'h0, 16'h0);
		row(`SRCC_OP_TRK_R, 2'h0, 16'h0, 2'h2, 16'h1);
		row(`SRCC_OP_OUT_W, 2'h0, 16'h1, 2'h0, 16'h0);
		row(`SRCC_OP_OUT_R, 2'h0, 16'h0, 2'h2, 16'h1);
		row(`SRCC_OP_OEN_W, 2'h0, 16'hffff, 2'h0, 16'h0);
		row(`SRCC_OP_OEN_R, 2'h0, 16'h0, 2'h2, 16'h7fff);
		row(`SRCC_OP_SRE_W, 2'h0, 16'h00ff, 2'h0, 16'h0);
		row(`SRCC_OP_SRE_R, 2'h0, 16'h0, 2'h2, 16'h00bf);
		row(`SRCC_OP_OCOND_R, 2'h0, 16'h0, 2'h2, 16'h0);
		row(`SRCC_OP_MEAS_I, 2'h2, 16'h0, 2'h2, 16'h1234 ^ 16'h0011);
		row(`SRCC_OP_MEAS_V, 2'h3, 16'h0, 2'h2, 16'h0abc ^ 16'h0022);
		row(`SRCC_OP_TST, 2'h0, 16'h0, 2'h2, 16'h0);
		row(`SRCC_OP_SAV, 2'h0, 16'h0005, 2'h0, 16'h0);
		row(`SRCC_OP_RCL, 2'h0, 16'h0064, 2'h1, 16'h0);
		row(`SRCC_OP_CURR_W, 2'h0, 16'h0099, 2'h1, 16'h0);
		row(`SRCC_OP_OCP_W, 2'h1, 16'h0002, 2'h1, 16'h0);
		row(`SRCC_OP_TRK_W, 2'h0, 16'h0003, 2'h1, 16'h0);
		row(`SRCC_OP_ESE_W, 2'h0, 16'h0011, 2'h0, 16'h0);
		row(`SRCC_OP_ESE_R, 2'h0, 16'h0, 2'h2, 16'h0011);
		row(`SRCC_OP_OPC, 2'h0, 16'h0, 2'h0, 16'h0);
		row(`SRCC_OP_STB_R, 2'h0, 16'h0, 2'h2, 16'h0060);
		row(`SRCC_OP_ESR_R, 2'h0, 16'h0, 2'h2, 16'h0011);
		row(`SRCC_OP_STB_R, 2'h0, 16'h0, 2'h2, 16'h0000);
		row(`SRCC_OP_OEVT_R, 2'h0, 16'h0, 2'h2, 16'h0000);
		row(`SRCC_OP_PRESET, 2'h0, 16'h0, 2'h0, 16'h0);
		row(`SRCC_OP_OEN_R, 2'h0, 16'h0, 2'h2, 16'h0000);
		repeat (10) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		@(posedge REF_CLK);
		#1;
		dflt();
		for (i = 0; i < rows.size(); i = i + 1) begin
			cmd(rows[i].op, rows[i].ch, rows[i].arg);
			cmp({13'h0, RSP_LAST, RSP_VALID, ERR_PULSE}, {13'h0, rows[i].kind[1], rows[i].kind});
			if (rows[i].kind == 2'h2) begin
				cmp(RSP_DATA, rows[i].exp);
			end
		end
		// A completion sets event bit 0, which reaches the request line a cycle later.
		cmd(`SRCC_OP_OPC, 2'h0, 16'h0);
		@(posedge REF_CLK);
		#1;
		cmp({15'h0, SRQ}, 16'h0001);
		cmd(`SRCC_OP_CLS, 2'h0, 16'h0);
		@(posedge REF_CLK);
		#1;
		cmp({15'h0, SRQ}, 16'h0000);
		@(posedge REF_CLK);
		TEST_FAULT <= 1'b1;
		cmd(`SRCC_OP_TST, 2'h0, 16'h0);
		cmp(RSP_DATA, 16'hfed4);
		// A completion query stays unanswered until the pending work ends.
		@(posedge REF_CLK);
		OP_PENDING <= 1'b1;
		cmd(`SRCC_OP_OPC_Q, 2'h0, 16'h0);
		cmp({15'h0, CMD_READY}, 16'h0);
		repeat (3) @(posedge REF_CLK);
		OP_PENDING <= 1'b0;
		for (k = 0; k < 8 && RSP_VALID !== 1'b1; k = k + 1) begin
			@(posedge REF_CLK);
			#1;
		end
		if (k == 8) begin
			errors = errors + 1;
			summarize();
		end
		cmp(RSP_DATA, 16'h0031);
		// Wait and completion both stall the port until the pending work ends.
		@(posedge REF_CLK);
		OP_PENDING <= 1'b1;
		cmd(`SRCC_OP_WAI, 2'h0, 16'h0);
		cmp({15'h0, CMD_READY}, 16'h0);
		@(posedge REF_CLK);
		OP_PENDING <= 1'b0;
		cmd(`SRCC_OP_CLS, 2'h0, 16'h0);
		@(posedge REF_CLK);
		OP_PENDING <= 1'b1;
		cmd(`SRCC_OP_OPC, 2'h0, 16'h0);
		cmp({15'h0, CMD_READY}, 16'h0);
		@(posedge REF_CLK);
		OP_PENDING <= 1'b0;
		cmd(`SRCC_OP_ESR_R, 2'h0, 16'h0);
		cmp(RSP_DATA, 16'h0001);
		// A trip blocks settings until the messages are cleared.
		@(posedge REF_CLK);
		PROT_TRIP <= 3'h4;
		@(posedge REF_CLK);
		PROT_TRIP <= 3'h0;
		cmd(`SRCC_OP_CURR_W, 2'h1, 16'h0055);
		cmp({12'h0, PROT_MSG, ERR_PULSE}, 16'h0009);
		cmd(`SRCC_OP_PCLR, 2'h0, 16'h0);
		cmd(`SRCC_OP_CURR_W, 2'h1, 16'h0055);
		cmp(SET_I[15:0], 16'h0055);
		cmd(`SRCC_OP_IDN, 2'h0, 16'h0);
		for (i = 3; i >= 0; i = i - 1) begin
			@(posedge REF_CLK);
			#1;
			cmp(RSP_VALID === 1'b1 ? RSP_DATA : 16'hdead, IDW[16*i +: 16]);
		end
		// Reset defaults the settings but the saved setup survives it.
		cmd(`SRCC_OP_RST, 2'h0, 16'h0);
		dflt();
		cmd(`SRCC_OP_RCL, 2'h0, 16'h0005);
		cmp(SET_I[31:16], 16'h1234);
		summarize();
	end
endmodule
